// [inc/fw_map.svh]
`ifndef FW_MAP_SVH
`define FW_MAP_SVH

// register offsets
`define FW_ADDR_LO 8'hac
`define FW_ADDR_HI 8'had
`define FW_CTRL    8'hae
`define FW_WDATA   8'haf
`define FW_TIMING  8'hab
`define FW_STATUS  8'haa

// control register bits
`define FW_CTL_ERASE 0
`define FW_CTL_WRITE 1
`define FW_CTL_CHIP  2
`define FW_CTL_SWBSY 6
`define FW_CTL_BUSY  7

// status register bits, write 1 to clear
`define FW_ST_VIOL 0
`define FW_ST_TMO  1

// array geometry
`define FW_WORD_BITS   32
`define FW_ADDR_BITS   15
`define FW_PAGE_MSB    6
`define FW_PAGE_LSB    1
`define FW_PAGE_WORDS  16'h0200
`define FW_ARRAY_WORDS 16'h8000
`define FW_PROG_LIMIT  2'h2

// timing
`define FW_CLK_NS     40
`define FW_TMO_NS     40000
`define FW_TMO_CYC    10'((`FW_TMO_NS) / (`FW_CLK_NS))
`define FW_NOM_MHZ    32
`define FW_NOM_FWT    42
`define FW_FWT_RST    6'(`FW_NOM_FWT)
`define FW_PROG_US    20
`define FW_PERASE_US  20000
`define FW_CERASE_US  200000
`define FW_TICKS(us)  (((us) * `FW_NOM_MHZ + `FW_NOM_FWT - 1) / `FW_NOM_FWT)
`define FW_PROG_TICKS 20'(`FW_TICKS(`FW_PROG_US))

`endif

// [inc/fw_pkg.sv]
package fw_pkg;

  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_ERASE,
    DEV_COLLECT,
    DEV_PROG
  } fw_dev_state_t;

  typedef struct packed {
    fw_dev_state_t st;
    logic [6:0]    addrHi;
    logic [7:0]    addrLo;
    logic [5:0]    program_timing_value;
    logic [14:0]   wordAddr;
    logic [23:0]   byteBuf;
    logic [1:0]    byteIdx;
    logic [5:0]    divCnt;
    logic [19:0]   tickCnt;
    logic [9:0]    toCnt;
    logic [15:0]   sweep;
    logic          chip;
    logic          writeAfter;
    logic          swBusy;
    logic          dmaReq;
    logic          viol;
    logic          tmo;
    logic [7:0]    rdata;
    logic [31:0]   arrRdata;
  } fw_dev_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_ALO,
    HST_AHI,
    HST_FWT,
    HST_CTL,
    HST_RUN,
    HST_POLL,
    HST_WAIT
  } fw_hst_state_t;

  typedef struct packed {
    fw_hst_state_t st;
    logic [14:0]   addr;
    logic          erase;
    logic [5:0]    program_timing_value;
    logic [15:0]   len;
    logic          wantWrite;
    logic          pend;
    logic [7:0]    sfrAddr;
    logic [7:0]    sfrWdata;
    logic          sfrWr;
    logic          sfrRd;
    logic          arrRd;
    logic [14:0]   arrAddr;
    logic [7:0]    ctrlStatus;
  } fw_hst_t;

endpackage

// [inc/fw_sfr_if.sv]
interface fw_sfr_if;
  logic [7:0]  sfrAddr;
  logic [7:0]  sfrWdata;
  logic        sfrWr;
  logic        sfrRd;
  logic [7:0]  sfrRdata;
  logic        dmaReq;
  logic        arrRd;
  logic [14:0] arrAddr;
  logic [31:0] arrRdata;

  modport dev (
    input  sfrAddr, sfrWdata, sfrWr, sfrRd, arrRd, arrAddr,
    output sfrRdata, dmaReq, arrRdata
  );
  modport host (
    output sfrAddr, sfrWdata, sfrWr, sfrRd, arrRd, arrAddr,
    input  sfrRdata, dmaReq, arrRdata
  );
endinterface

// [src/fw_dev_ctrl.sv]
// Behaviour
// R1: 2 KB erase pages, 32-bit program words
// R2: program address is 15-bit word address
// R3: page erase uses address_high bits 6:1
// R4: programming only clears bits, twice per erase
// R5: erased bits read as one
// R6: write_start begins programming at loaded address
// R7: word_write_busy high while a word programs
// R8: bytes assembled LSB first, fourth starts programming
// R9: sequence accepts any number of consecutive words
// R10: issuing code must run from RAM
// R11: array access while busy is a violation
// R12: starting a write never stalls the CPU
// R13: DMA request whenever data port is ready
// R14: DMA uses single byte transfers, multiple-of-four
// R15: write_start issues first DMA request immediately
// R16: flash-resident launch aligns trigger instruction
// R17: 40 us per-word timeout aborts the write
// R18: after timeout software restarts and resends word
// R19: page erase 20 ms, chip 200 ms, word 20 us
// R20: erase runs before write when both set
// R21: op_active shows any operation in progress
// R22: timing derives from program_timing_value, reset 0x2A
// R23: internal word address advances after each word
`include "fw_map.svh"

module fw_dev_ctrl #(
  parameter int unsigned PERASE_TICKS = `FW_TICKS(`FW_PERASE_US),
  parameter int unsigned CERASE_TICKS = `FW_TICKS(`FW_CERASE_US)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // special-function bus, DMA and array read port
  fw_sfr_if.dev     bus,
  // observation
  output wire logic opActive,
  output wire logic violation
);

  fw_pkg::fw_dev_t s_q;
  fw_pkg::fw_dev_t s_d;

  // the array and its per-word program counters live outside the state
  // struct: no reset, one word touched per cycle
  logic [31:0] mem  [0:`FW_ARRAY_WORDS-1];
  logic [1:0]  pcnt [0:`FW_ARRAY_WORDS-1];

  logic        memWe;
  logic [14:0] memAddr;
  logic [31:0] memWdata;
  logic [1:0]  cntWdata;
  logic        tick;
  logic [19:0] eraseTicks;
  logic [15:0] eraseWords;

  assign bus.sfrRdata = s_q.rdata;
  assign bus.dmaReq   = s_q.dmaReq;
  assign bus.arrRdata = s_q.arrRdata;
  assign opActive     = (s_q.st != fw_pkg::DEV_IDLE); // R21
  assign violation    = s_q.viol;

  // fwt of zero is treated as one so the tick never stops
  assign tick = ({1'b0, s_q.divCnt} + 7'h01 >= {1'b0, s_q.program_timing_value}); // R22
  assign eraseTicks = s_q.chip ? 20'(CERASE_TICKS) : 20'(PERASE_TICKS); // R19
  assign eraseWords = s_q.chip ? `FW_ARRAY_WORDS : `FW_PAGE_WORDS; // R1

  always_comb begin
    logic goCollect;
    logic tmoSet;
    logic [31:0] word;
    s_d       = s_q;
    goCollect = 1'b0;
    tmoSet    = 1'b0;
    word      = '0;
    memWe     = 1'b0;
    memAddr   = s_q.wordAddr;
    memWdata  = '1;
    cntWdata  = 2'h0;
    s_d.dmaReq = 1'b0;
    s_d.rdata  = 8'h00;
    s_d.divCnt = tick ? 6'h00 : s_q.divCnt + 6'h01;

    // state sequencing
    case (s_q.st)
      fw_pkg::DEV_IDLE: begin
      end
      fw_pkg::DEV_ERASE: begin
        if (s_q.sweep != eraseWords) begin
          memWe    = 1'b1;
          memWdata = '1; // R5
          cntWdata = 2'h0;
          if (s_q.chip) begin
            memAddr = s_q.sweep[14:0];
          end else begin
            memAddr = {s_q.addrHi[`FW_PAGE_MSB:`FW_PAGE_LSB], s_q.sweep[8:0]}; // R3
          end
          s_d.sweep = s_q.sweep + 16'h0001;
        end
        if (tick && s_q.tickCnt != eraseTicks) begin
          s_d.tickCnt = s_q.tickCnt + 20'h00001;
        end
        if (s_q.sweep == eraseWords && s_q.tickCnt == eraseTicks) begin
          if (s_q.writeAfter) begin
            goCollect = 1'b1; // R20
          end else begin
            s_d.st = fw_pkg::DEV_IDLE;
          end
        end
      end
      fw_pkg::DEV_COLLECT: begin
        if (s_q.toCnt == `FW_TMO_CYC - 10'h001) begin
          // stalled feeder: drop the partial word, keep the address
          s_d.st         = fw_pkg::DEV_IDLE; // R17 R18
          s_d.writeAfter = 1'b0;
          s_d.byteIdx    = 2'h0;
          s_d.tmo        = 1'b1;
          tmoSet         = 1'b1;
        end else begin
          s_d.toCnt = s_q.toCnt + 10'h001;
        end
      end
      fw_pkg::DEV_PROG: begin
        if (tick) begin
          s_d.tickCnt = s_q.tickCnt + 20'h00001;
        end
        if (s_q.tickCnt == `FW_PROG_TICKS) begin // R19
          s_d.swBusy   = 1'b0; // R7
          s_d.wordAddr = s_q.wordAddr + 15'h0001; // R23 R9
          s_d.st       = fw_pkg::DEV_COLLECT;
          s_d.toCnt    = 10'h000;
          s_d.dmaReq   = 1'b1; // R13
        end
      end
      default: begin
        s_d.st = fw_pkg::DEV_IDLE;
      end
    endcase

    // bus writes; a write to the control register while busy is ignored
    if (bus.sfrWr) begin
      case (bus.sfrAddr)
        `FW_ADDR_LO: begin
          s_d.addrLo = bus.sfrWdata;
        end
        `FW_ADDR_HI: begin
          s_d.addrHi = bus.sfrWdata[6:0];
        end
        `FW_TIMING: begin
          s_d.program_timing_value = bus.sfrWdata[5:0];
        end
        `FW_STATUS: begin
          if (bus.sfrWdata[`FW_ST_VIOL]) begin
            s_d.viol = 1'b0;
          end
          // a timeout in the same cycle beats the clear
          if (bus.sfrWdata[`FW_ST_TMO] && !tmoSet) begin
            s_d.tmo = 1'b0;
          end
        end
        `FW_CTRL: begin
          if (s_q.st == fw_pkg::DEV_IDLE) begin
            if (bus.sfrWdata[`FW_CTL_ERASE] || bus.sfrWdata[`FW_CTL_CHIP]) begin
              s_d.st         = fw_pkg::DEV_ERASE;
              s_d.chip       = bus.sfrWdata[`FW_CTL_CHIP];
              s_d.writeAfter = bus.sfrWdata[`FW_CTL_WRITE]; // R20
              s_d.sweep      = 16'h0000;
              s_d.tickCnt    = 20'h00000;
            end else if (bus.sfrWdata[`FW_CTL_WRITE]) begin
              goCollect = 1'b1; // R6 R12
            end
          end
        end
        `FW_WDATA: begin
          if (s_q.st == fw_pkg::DEV_COLLECT) begin
            s_d.toCnt = 10'h000;
            if (s_q.byteIdx == 2'h3) begin
              word = {bus.sfrWdata, s_q.byteBuf}; // R8
              memWe    = (pcnt[s_q.wordAddr] != `FW_PROG_LIMIT); // R4
              memAddr  = s_q.wordAddr; // R2
              memWdata = mem[s_q.wordAddr] & word; // R4
              cntWdata = pcnt[s_q.wordAddr] + 2'h1;
              s_d.st      = fw_pkg::DEV_PROG;
              s_d.swBusy  = 1'b1; // R7
              s_d.tickCnt = 20'h00000;
              s_d.byteIdx = 2'h0;
            end else begin
              s_d.byteBuf = {bus.sfrWdata, s_q.byteBuf[23:8]}; // R8
              s_d.byteIdx = s_q.byteIdx + 2'h1;
              s_d.dmaReq  = 1'b1; // R13
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (goCollect) begin
      s_d.st         = fw_pkg::DEV_COLLECT;
      s_d.wordAddr   = {s_q.addrHi, s_q.addrLo}; // R2 R6
      s_d.byteIdx    = 2'h0;
      s_d.toCnt      = 10'h000;
      s_d.writeAfter = 1'b0;
      s_d.dmaReq     = 1'b1; // R15
    end

    // bus reads, data in the following cycle only
    if (bus.sfrRd) begin
      case (bus.sfrAddr)
        `FW_ADDR_LO: s_d.rdata = s_q.addrLo;
        `FW_ADDR_HI: s_d.rdata = {1'b0, s_q.addrHi};
        `FW_TIMING:  s_d.rdata = {2'b00, s_q.program_timing_value};
        `FW_STATUS: begin
          s_d.rdata = 8'h00;
          s_d.rdata[`FW_ST_VIOL] = s_q.viol;
          s_d.rdata[`FW_ST_TMO]  = s_q.tmo;
        end
        `FW_CTRL: begin
          s_d.rdata = 8'h00;
          s_d.rdata[`FW_CTL_BUSY]  = (s_q.st != fw_pkg::DEV_IDLE); // R21
          s_d.rdata[`FW_CTL_SWBSY] = s_q.swBusy; // R7
          s_d.rdata[`FW_CTL_WRITE] = (s_q.st == fw_pkg::DEV_COLLECT) ||
                                     (s_q.st == fw_pkg::DEV_PROG) || s_q.writeAfter;
          s_d.rdata[`FW_CTL_ERASE] = (s_q.st == fw_pkg::DEV_ERASE);
        end
        default: s_d.rdata = 8'h00;
      endcase
    end

    // array read port; reads while a word or page is busy are flagged,
    // and the set wins over a same-cycle clear
    if (bus.arrRd) begin
      s_d.arrRdata = mem[bus.arrAddr];
      if (s_q.swBusy || s_q.st == fw_pkg::DEV_ERASE) begin
        s_d.viol = 1'b1; // R11
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q     <= '0;
      s_q.st  <= fw_pkg::DEV_IDLE;
      s_q.program_timing_value <= `FW_FWT_RST; // R22
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mem[memAddr]  <= memWdata;
      pcnt[memAddr] <= cntWdata;
    end
  end

endmodule

// [src/fw_host_ctrl.sv]
// drives the controller the way software plus a DMA channel would
`include "fw_map.svh"

module fw_host_ctrl (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // link to the controller
  fw_sfr_if.host           bus,
  // command
  input  wire logic        cmdStart,
  input  wire logic [14:0] cmdAddr,
  input  wire logic        cmdErase,
  input  wire logic [5:0]  cmdFwt,
  input  wire logic [15:0] cmdLen,
  // source byte stream
  input  wire logic [7:0]  srcByte,
  input  wire logic        srcValid,
  output wire logic        srcReady,
  // status and array reads
  output wire logic        hostBusy,
  output wire logic [7:0]  ctrlStatus,
  input  wire logic        userArrRd,
  input  wire logic [14:0] userArrAddr,
  output wire logic [31:0] userArrData
);

  fw_pkg::fw_hst_t s_q;
  fw_pkg::fw_hst_t s_d;

  assign bus.sfrAddr  = s_q.sfrAddr;
  assign bus.sfrWdata = s_q.sfrWdata;
  assign bus.sfrWr    = s_q.sfrWr;
  assign bus.sfrRd    = s_q.sfrRd;
  assign bus.arrRd    = s_q.arrRd;
  assign bus.arrAddr  = s_q.arrAddr;
  assign userArrData  = bus.arrRdata;
  assign ctrlStatus   = s_q.ctrlStatus;
  assign hostBusy     = (s_q.st != fw_pkg::HST_IDLE);
  // a request may already be on the link in the cycle it is consumed
  assign srcReady = (s_q.st == fw_pkg::HST_RUN) && (s_q.pend || bus.dmaReq) && srcValid; // R14

  always_comb begin
    s_d          = s_q;
    s_d.sfrWr    = 1'b0;
    s_d.sfrRd    = 1'b0;
    s_d.arrRd    = userArrRd;
    s_d.arrAddr  = userArrAddr;
    case (s_q.st)
      fw_pkg::HST_IDLE: begin
        if (cmdStart) begin
          s_d.addr      = cmdAddr;
          s_d.erase     = cmdErase;
          s_d.program_timing_value       = cmdFwt;
          s_d.len       = cmdLen;
          s_d.wantWrite = (cmdLen != 16'h0000);
          s_d.pend      = 1'b0;
          s_d.st        = fw_pkg::HST_ALO;
        end
      end
      fw_pkg::HST_ALO: begin
        s_d.sfrWr    = 1'b1;
        s_d.sfrAddr  = `FW_ADDR_LO;
        s_d.sfrWdata = s_q.addr[7:0];
        s_d.st       = fw_pkg::HST_AHI;
      end
      fw_pkg::HST_AHI: begin
        s_d.sfrWr    = 1'b1;
        s_d.sfrAddr  = `FW_ADDR_HI;
        s_d.sfrWdata = {1'b0, s_q.addr[14:8]};
        s_d.st       = fw_pkg::HST_FWT;
      end
      fw_pkg::HST_FWT: begin
        s_d.sfrWr    = 1'b1;
        s_d.sfrAddr  = `FW_TIMING;
        s_d.sfrWdata = {2'b00, s_q.program_timing_value}; // R22
        s_d.st       = fw_pkg::HST_CTL;
      end
      fw_pkg::HST_CTL: begin
        s_d.sfrWr    = 1'b1;
        s_d.sfrAddr  = `FW_CTRL;
        s_d.sfrWdata = 8'h00;
        s_d.sfrWdata[`FW_CTL_WRITE] = s_q.wantWrite; // R6 R10 R16
        s_d.sfrWdata[`FW_CTL_ERASE] = s_q.erase;
        s_d.st = s_q.wantWrite ? fw_pkg::HST_RUN : fw_pkg::HST_POLL;
      end
      fw_pkg::HST_RUN: begin
        if (bus.dmaReq) begin
          s_d.pend = 1'b1;
        end
        if (srcReady) begin
          s_d.pend     = 1'b0;
          s_d.sfrWr    = 1'b1;
          s_d.sfrAddr  = `FW_WDATA;
          s_d.sfrWdata = srcByte; // R14
          s_d.len      = s_q.len - 16'h0001;
          if (s_q.len == 16'h0001) begin
            s_d.st = fw_pkg::HST_POLL;
          end
        end
      end
      fw_pkg::HST_POLL: begin
        s_d.sfrRd   = 1'b1;
        s_d.sfrAddr = `FW_CTRL;
        s_d.st      = fw_pkg::HST_WAIT;
      end
      fw_pkg::HST_WAIT: begin
        // the answer stands one cycle after the strobe, so skip the strobe cycle
        if (!s_q.sfrRd) begin
          s_d.ctrlStatus = bus.sfrRdata;
          // a write is done once the last word is out; erase waits for op idle
          if (s_q.wantWrite ? !bus.sfrRdata[`FW_CTL_SWBSY] : !bus.sfrRdata[`FW_CTL_BUSY]) begin // R11
            s_d.st = fw_pkg::HST_IDLE;
          end else begin
            s_d.st = fw_pkg::HST_POLL;
          end
        end
      end
      default: begin
        s_d.st = fw_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q    <= '0;
      s_q.st <= fw_pkg::HST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [tb/fw_link_chk.sv]
`include "fw_map.svh"

module fw_link_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // link signals
  input wire logic [7:0]  sfrAddr,
  input wire logic [7:0]  sfrWdata,
  input wire logic        sfrWr,
  input wire logic        sfrRd,
  input wire logic [7:0]  sfrRdata,
  input wire logic        dmaReq,
  input wire logic        arrRd,
  input wire logic [14:0] arrAddr,
  input wire logic [31:0] arrRdata
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic [1:0]  byteCnt_q;
  logic [10:0] idleCnt_q;
  wire         dataWr = sfrWr && sfrAddr == `FW_WDATA;
  wire         ctlWr  = sfrWr && sfrAddr == `FW_CTRL;

  // byte position within the current word; a control write restarts it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byteCnt_q <= 2'h0;
      idleCnt_q <= 11'h000;
    end else begin
      byteCnt_q <= ctlWr ? 2'h0 : (dataWr ? byteCnt_q + 2'h1 : byteCnt_q);
      idleCnt_q <= sfrWr ? 11'h000 : (idleCnt_q == 11'h7ff ? idleCnt_q : idleCnt_q + 11'h001);
    end
  end

  property p_one_strobe;
    !(sfrWr && sfrRd);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobe together");

  property p_rd_zero;
    !sfrRd |=> sfrRdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer cycle");

  property p_req_pulse;
    dmaReq |=> !dmaReq;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");

  property p_start_req;
    ctlWr && sfrWdata == 8'h02 |=> dmaReq;
  endproperty
  a_start_req: assert property (p_start_req) else $error("no request after start");

  property p_byte_req;
    dataWr && byteCnt_q != 2'h3 |=> dmaReq;
  endproperty
  a_byte_req: assert property (p_byte_req) else $error("no request for next byte");

  property p_word_busy;
    dataWr && byteCnt_q == 2'h3 |=> !dmaReq [*8];
  endproperty
  a_word_busy: assert property (p_word_busy) else $error("request while word programs");

  property p_word_done;
    dataWr && byteCnt_q == 2'h3 |-> ##[16:1000] dmaReq;
  endproperty
  a_word_done: assert property (p_word_done) else $error("no request after word");

  property p_idle_quiet;
    dmaReq |-> idleCnt_q <= 11'd1000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("request after timeout");

  property p_hold_data;
    !arrRd |=> $stable(arrRdata);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("array data changed unasked");

  c_word: cover property (dataWr && byteCnt_q == 2'h3);
  c_erase_write: cover property (ctlWr && sfrWdata == 8'h03);
  c_arr: cover property (arrRd && arrAddr == 15'h0a07);
endmodule

// [tb/embedded_flash_write_controller_tb.sv]
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module embedded_flash_write_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk    = 1'b0;
  logic        nrst        = 1'b0;
  logic        cmdStart    = 1'b0;
  logic [14:0] cmdAddr     = 15'h0000;
  logic        cmdErase    = 1'b0;
  logic [5:0]  cmdFwt      = 6'h2a;
  logic [15:0] cmdLen      = 16'h0000;
  logic [7:0]  srcByte     = 8'h00;
  logic        srcValid    = 1'b0;
  logic        userArrRd   = 1'b0;
  logic [14:0] userArrAddr = 15'h0000;
  wire         srcReady;
  wire         hostBusy;
  wire         opActive;
  wire         violation;
  wire  [7:0]  ctrlStatus;
  wire  [31:0] userArrData;
  int          failures    = 0;
  int          compares    = 0;
  logic [31:0] seed        = 32'h94c1a864;
  logic [7:0]  srcQ[$];
  logic [31:0] expQ[$];
  logic [31:0] mem[int];
  int          progs[int];

  fw_sfr_if link ();

  // short erase counts keep the run brief
  fw_dev_ctrl #(.PERASE_TICKS(20), .CERASE_TICKS(40)) fw_dev_ctrl_inst (.core_clk(core_clk), .nrst(nrst),
    .bus(link), .opActive(opActive), .violation(violation));

  fw_host_ctrl fw_host_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .bus(link), .cmdStart(cmdStart),
    .cmdAddr(cmdAddr), .cmdErase(cmdErase), .cmdFwt(cmdFwt), .cmdLen(cmdLen), .srcByte(srcByte),
    .srcValid(srcValid), .srcReady(srcReady), .hostBusy(hostBusy), .ctrlStatus(ctrlStatus),
    .userArrRd(userArrRd), .userArrAddr(userArrAddr), .userArrData(userArrData));

  fw_link_chk fw_link_chk_inst (.core_clk(core_clk), .nrst(nrst), .sfrAddr(link.sfrAddr),
    .sfrWdata(link.sfrWdata), .sfrWr(link.sfrWr), .sfrRd(link.sfrRd), .sfrRdata(link.sfrRdata),
    .dmaReq(link.dmaReq), .arrRd(link.arrRd), .arrAddr(link.arrAddr), .arrRdata(link.arrRdata));

  initial forever #20 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // byte stream source; an idle data line shows the inverse so a stale byte cannot pass
  always @(posedge core_clk) begin
    if (srcValid === 1'b1 && srcReady === 1'b1)
      void'(srcQ.pop_front());
    srcValid <= (srcQ.size() != 0);
    srcByte <= (srcQ.size() != 0) ? srcQ[0] : ~srcByte;
  end

  initial begin
    logic [31:0] expV;
    forever begin
      @(posedge core_clk);
      if (userArrRd === 1'b1) begin
        repeat (3) @(posedge core_clk);
        expV = expQ.pop_front();
        `CHK(userArrData, expV)
      end
    end
  end

  task automatic rd(input logic [14:0] a, input logic [31:0] e);
    expQ.push_back(e);
    userArrAddr <= a;
    userArrRd <= 1'b1;
    @(posedge core_clk);
    userArrRd <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic wait_flag(input bit busyOnly, output int n);
    n = 0;
    while ((busyOnly ? hostBusy : (hostBusy | opActive)) !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 4000) begin
        failures++;
        complete_run();
      end
    end
  endtask

  task automatic run_cmd(input string name, input logic [14:0] a, input logic er, input logic [5:0] program_timing_value,
                         input int words, input bit probe);
    logic [31:0] w;
    int          n;
    int          base;
    base = {a[14:9], 9'h000};
    if (er)
      for (int i = 0; i < 512; i++) begin
        mem[base + i] = 32'hffffffff;
        progs[base + i] = 0;
      end
    for (int i = 0; i < words; i++) begin
      seed = lfsr(seed);
      w = seed;
      for (int b = 0; b < 4; b++)
        srcQ.push_back(w[8*b +: 8]);
      if (progs[int'(a) + i] < 2)
        mem[int'(a) + i] &= w;
      progs[int'(a) + i]++;
    end
    cmdAddr <= a;
    cmdErase <= er;
    cmdFwt <= program_timing_value;
    cmdLen <= 16'(words * 4);
    cmdStart <= 1'b1;
    @(posedge core_clk);
    cmdStart <= 1'b0;
    if (probe) begin
      for (int i = 0; i < 400 && srcQ.size() != 0; i++)
        @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      rd(15'h0a07, mem['h0a07]);
    end
    repeat (2) @(posedge core_clk);
    wait_flag(1'b1, n);
    if (words > 0) begin
      `CHK(ctrlStatus[7:6], 2'b10)
      wait_flag(1'b0, n);
      `CHK(n > 980 && n < 1002, 1'b1)
    end else begin
      wait_flag(1'b0, n);
    end
    $display("test %s done", name);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    `CHK(violation, 1'b0)
    run_cmd("erase_then_write", 15'h0a05, 1'b1, 6'h01, 2, 1'b0);
    rd(15'h0a05, mem['h0a05]);
    rd(15'h0a06, mem['h0a06]);
    rd(15'h0a00, 32'hffffffff);
    rd(15'h0bff, 32'hffffffff);
    // second program ANDs in, third is skipped; first pass probes the array while busy
    for (int k = 0; k < 2; k++) begin
      run_cmd("reprogram", 15'h0a05, 1'b0, 6'h02, 1, k == 0);
      rd(15'h0a05, mem['h0a05]);
    end
    `CHK(violation, 1'b1)
    run_cmd("erase_only", 15'h0a05, 1'b1, 6'h01, 0, 1'b0);
    rd(15'h0a05, 32'hffffffff);
    run_cmd("slow_block", 15'h0a10, 1'b0, 6'h2a, 3, 1'b0);
    for (int k = 0; k < 3; k++)
      rd(15'(16 + k) | 15'h0a00, mem['h0a10 + k]);
    complete_run();
  end
endmodule
